//--- core/acad_decoder.sv
/*
  Second-stage classification action decoder: applies one action word
  to the forwarding context of the frame, two cycles after the lookup.
  Assumes the lookup gives action, rule index and context in one cycle.
*/
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module acad_decoder (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // Lookup side
  input wire logic action_valid_in,
  input wire logic [acad_pkg::ACTION_W-1:0] action_in,
  input wire logic [acad_pkg::RULE_W-1:0] rule_index_in,
  input wire acad_pkg::acad_ctx_type ctx_in,
  // Forwarding side
  output logic decision_valid_out,
  output acad_pkg::acad_dec_type decision_out,
  output logic rule_hit_irq_out,
  // Register port
  input wire logic [acad_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [acad_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [acad_pkg::DATA_W-1:0] reg_rdata_out
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [acad_pkg::PORT_W-1:0] apply_ports(
    input logic [acad_pkg::MODE_W-1:0] op,
    input logic [acad_pkg::PORT_W-1:0] vec,
    input acad_pkg::acad_ctx_type ctx
  );
    logic [acad_pkg::PORT_W-1:0] res;
    logic [acad_pkg::PORT_W-1:0] host;
    res = ctx.dest_mask;
    host = '0;
    host[acad_pkg::HOST_PORT_BIT] = 1'b1;
    case (op)
      acad_pkg::OP_OR_INTO_DESTINATION: res = ctx.dest_mask | vec;
      acad_pkg::OP_AND_VLAN: res = ctx.dest_mask & (ctx.vlan_mask & vec);
      acad_pkg::OP_REPLACE_GROUP: res = vec;
      acad_pkg::OP_REPLACE_ALL: res = vec;
      acad_pkg::OP_OR_WITH_GROUP_MASK: res = ctx.group_mask | vec;
      default: res = ctx.dest_mask;
    endcase
    // Host port keeps its own membership
    apply_ports = (res & ~host) | (ctx.dest_mask & host);
  endfunction : apply_ports

  function automatic logic [7:0] log_interval(
    input logic [acad_pkg::LOGINT_W-1:0] code,
    input logic macx
  );
    if (macx)
    begin
      log_interval = acad_pkg::LOG_NEG_BASE | {5'h00, code};
    end
    else
    begin
      log_interval = {5'h00, code};
    end
  endfunction : log_interval

  // ****************************************************************
  // Input stage and one-shot memory
  // ****************************************************************
  logic s1_valid;
  logic [acad_pkg::ACTION_W-1:0] s1_action;
  logic [acad_pkg::RULE_W-1:0] s1_rule;
  acad_pkg::acad_ctx_type s1_ctx;
  logic mem_rdata;
  logic mem_wr;
  logic [acad_pkg::RULE_W-1:0] mem_waddr;
  logic mem_wdata;
  logic last_wr;
  logic [acad_pkg::RULE_W-1:0] last_waddr;
  logic last_wdata;
  logic init_busy;
  logic [acad_pkg::RULE_W-1:0] init_addr;
  logic rearm_pend;
  logic [acad_pkg::RULE_W-1:0] rearm_addr;
  logic ctrl_enable;
  logic [15:0] hit_count;
  logic [acad_pkg::RULE_W-1:0] last_rule;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      s1_valid <= 1'b0;
      s1_action <= '0;
      s1_rule <= '0;
      s1_ctx <= '0;
    end
    else if (ce_in)
    begin
      s1_valid <= action_valid_in;
      s1_action <= action_in;
      s1_rule <= rule_index_in;
      s1_ctx <= ctx_in;
    end
  end

  acad_oneshot_mem u_mem (
    .mclk_in(mclk_in),
    .ce_in(ce_in),
    .wr_in(mem_wr),
    .wr_addr_in(mem_waddr),
    .wr_data_in(mem_wdata),
    .rd_addr_in(rule_index_in),
    .rd_data_out(mem_rdata)
  );

  // ****************************************************************
  // Field decode of the held action
  // ****************************************************************
  logic f_inner;
  logic f_force;
  logic [acad_pkg::STAGE_W-1:0] f_stage;
  logic f_oneshot;
  logic f_irq;
  logic f_copy;
  logic [acad_pkg::QUEUE_W-1:0] f_queue;
  logic f_xdis;
  logic f_lrn;
  logic f_rt;
  logic f_polon;
  logic [acad_pkg::POLIDX_W-1:0] f_polidx;
  logic f_ovr;
  logic [acad_pkg::LOGINT_W-1:0] f_logint;
  logic [acad_pkg::MODE_W-1:0] f_mode;
  logic [acad_pkg::PORT_W-1:0] f_vec;
  logic [acad_pkg::MIRROR_W-1:0] f_mirror;
  logic [acad_pkg::REWCMD_W-1:0] f_rew;
  logic f_macx;
  logic consumed;
  logic applied;
  logic oneshot_fire;
  logic [acad_pkg::QMASK_W-1:0] qbit;

  // Fixed layout from bit 0, contiguous up to bit 93; f_macx sits alone at bit 141
  assign f_inner = s1_action[acad_pkg::POS_INNER];
  assign f_force = s1_action[acad_pkg::POS_FORCE];
  assign f_stage = s1_action[acad_pkg::POS_STAGE +: acad_pkg::STAGE_W];
  assign f_oneshot = s1_action[acad_pkg::POS_ONESHOT];
  assign f_irq = s1_action[acad_pkg::POS_IRQ];
  assign f_copy = s1_action[acad_pkg::POS_COPY];
  assign f_queue = s1_action[acad_pkg::POS_QUEUE +: acad_pkg::QUEUE_W];
  assign f_xdis = s1_action[acad_pkg::POS_XDIS];
  assign f_lrn = s1_action[acad_pkg::POS_LRN];
  assign f_rt = s1_action[acad_pkg::POS_RT];
  assign f_polon = s1_action[acad_pkg::POS_POLON];
  assign f_polidx = s1_action[acad_pkg::POS_POLIDX +: acad_pkg::POLIDX_W];
  assign f_ovr = s1_action[acad_pkg::POS_OVRTERM];
  assign f_logint = s1_action[acad_pkg::POS_LOGINT +: acad_pkg::LOGINT_W];
  assign f_mode = s1_action[acad_pkg::POS_MODE +: acad_pkg::MODE_W];
  assign f_vec = s1_action[acad_pkg::POS_PORTVEC +: acad_pkg::PORT_W];
  assign f_mirror = s1_action[acad_pkg::POS_MIRROR +: acad_pkg::MIRROR_W];
  assign f_rew = s1_action[acad_pkg::POS_REWCMD +: acad_pkg::REWCMD_W];
  assign f_macx = s1_action[acad_pkg::POS_MACX];

  // Forward a write made to the same rule one cycle earlier
  assign consumed = init_busy ? 1'b0 :
    ((last_wr && last_waddr == s1_rule) ? last_wdata : mem_rdata);
  // Terminated frames take the action only when overridden
  assign applied = s1_valid && ctrl_enable &&
    (!s1_ctx.terminated || f_ovr);
  assign oneshot_fire = applied && f_oneshot && !consumed;
  assign qbit = 8'h01 << f_queue;

  // ****************************************************************
  // Decision build
  // ****************************************************************
  acad_pkg::acad_dec_type next_dec;

  always_comb
  begin
    next_dec = '0;
    next_dec.applied = applied;
    next_dec.dest_mask = s1_ctx.dest_mask;
    next_dec.sticky = s1_ctx.sticky;
    next_dec.host_req = s1_ctx.host_req;
    next_dec.host_qmask = s1_ctx.host_qmask;
    next_dec.stage_point = s1_ctx.stage_point;
    if (applied)
    begin
      next_dec.inner_point = f_inner;
      if (f_force)
      begin
        next_dec.stage_point = f_stage;
        next_dec.stage_act_none = (f_stage == acad_pkg::STAGE_NONE);
      end
      if (f_xdis)
      begin
        next_dec.host_req = 1'b0;
        next_dec.host_qmask = '0;
      end
      // Copy-always covers every hit, one-shot only the first
      if (f_copy || oneshot_fire)
      begin
        next_dec.host_req = 1'b1;
        next_dec.host_qmask = next_dec.host_qmask | qbit;
      end
      next_dec.learn_block = f_lrn;
      next_dec.route_block = f_rt;
      next_dec.police_valid = f_polon;
      next_dec.police_index = f_polon ? f_polidx : '0;
      next_dec.sip_valid = !f_polon;
      next_dec.sip_index = f_polon ? '0 : f_polidx;
      next_dec.mirror_valid = (f_mirror != '0);
      next_dec.mirror_probe = f_mirror - 2'h1;
      next_dec.rewriter_command = f_rew;
      if (f_rew[acad_pkg::POS_REW_PTPSEQ])
      begin
        next_dec.log_valid = 1'b1;
        next_dec.log_interval = log_interval(f_logint, f_macx);
        next_dec.rewriter_command[acad_pkg::POS_REW_PTPSEQ] = 1'b0;
        next_dec.rewriter_command[acad_pkg::POS_REW_SEQLO] = 1'b0;
      end
      if (!s1_ctx.sticky)
      begin
        next_dec.dest_mask = apply_ports(f_mode, f_vec, s1_ctx);
        if (f_mode == acad_pkg::OP_REPLACE_ALL)
        begin
          next_dec.sticky = 1'b1;
        end
        if (f_mode == acad_pkg::OP_REDIRECT_BY_GROUP)
        begin
          next_dec.sticky = 1'b1;
          next_dec.redir_valid = 1'b1;
          next_dec.redir_index = f_vec[acad_pkg::GROUP_W-1:0];
          next_dec.filt_src = f_vec[acad_pkg::POS_FILT_SRC];
          next_dec.filt_aggr = f_vec[acad_pkg::POS_FILT_AGGR];
          next_dec.filt_vlan = f_vec[acad_pkg::POS_FILT_VLAN];
        end
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      decision_valid_out <= 1'b0;
      decision_out <= '0;
      rule_hit_irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      decision_valid_out <= s1_valid;
      decision_out <= next_dec;
      rule_hit_irq_out <= applied && f_irq;
    end
  end

  // ****************************************************************
  // One-shot memory writes: consume, rearm, clear sweep
  // ****************************************************************
  always_comb
  begin
    mem_wr = 1'b0;
    mem_waddr = rearm_addr;
    mem_wdata = 1'b0;
    if (init_busy)
    begin
      mem_wr = 1'b1;
      mem_waddr = init_addr;
    end
    else if (oneshot_fire)
    begin
      mem_wr = 1'b1;
      mem_waddr = s1_rule;
      mem_wdata = 1'b1;
    end
    else if (rearm_pend)
    begin
      mem_wr = 1'b1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      last_wr <= 1'b0;
      last_waddr <= '0;
      last_wdata <= 1'b0;
    end
    else if (ce_in)
    begin
      last_wr <= mem_wr;
      last_waddr <= mem_waddr;
      last_wdata <= mem_wdata;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      init_busy <= 1'b1;
      init_addr <= '0;
    end
    else if (ce_in && init_busy)
    begin
      init_addr <= init_addr + 8'h01;
      if (init_addr == 8'hFF)
      begin
        init_busy <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      rearm_pend <= 1'b0;
      rearm_addr <= '0;
    end
    else if (ce_in)
    begin
      if (reg_wr_in && reg_addr_in == acad_pkg::REG_REARM)
      begin
        rearm_pend <= 1'b1;
        rearm_addr <= reg_wdata_in[acad_pkg::RULE_W-1:0];
      end
      else if (mem_wr && !init_busy && !oneshot_fire)
      begin
        rearm_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ctrl_enable <= acad_pkg::CTRL_ENABLE_RESET;
    end
    else if (ce_in && reg_wr_in && reg_addr_in == acad_pkg::REG_CTRL)
    begin
      ctrl_enable <= reg_wdata_in[acad_pkg::CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      hit_count <= acad_pkg::HIT_COUNT_RESET;
      last_rule <= '0;
    end
    else if (ce_in && applied)
    begin
      hit_count <= hit_count + 16'h0001;
      last_rule <= s1_rule;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      reg_rdata_out <= '0;
    end
    else if (ce_in)
    begin
      reg_rdata_out <= '0;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          acad_pkg::REG_CTRL:
            reg_rdata_out[acad_pkg::CTRL_ENABLE_BIT] <= ctrl_enable;
          acad_pkg::REG_STATUS:
          begin
            reg_rdata_out[acad_pkg::STATUS_BUSY_BIT] <= init_busy;
            reg_rdata_out[acad_pkg::STATUS_COUNT_POS +: 16] <= hit_count;
          end
          acad_pkg::REG_LAST:
            reg_rdata_out[acad_pkg::RULE_W-1:0] <= last_rule;
          default:
            reg_rdata_out <= '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (srst_in);

  // Sweep time leaves every one-shot armed, so skip it
  sequence seq_oneshot_hit;
    ce_in && oneshot_fire && !f_copy && !init_busy;
  endsequence

  sequence seq_same_again;
    ce_in && applied && f_oneshot && !f_copy && s1_rule == $past(s1_rule);
  endsequence

  a_force_stage_none: assert property (
    ce_in && applied && f_force |=>
      decision_out.stage_point == $past(f_stage) &&
      decision_out.stage_act_none == ($past(f_stage) == 5'h00))
    else $error("forced stage not applied");
  a_irq_per_hit: assert property (
    ce_in |=> rule_hit_irq_out == $past(applied && f_irq))
    else $error("rule hit interrupt mismatch");
  a_copy_to_queue: assert property (
    ce_in && applied && f_copy |=>
      decision_out.host_req && decision_out.host_qmask[$past(f_queue)])
    else $error("host copy queue bit missing");
  a_extract_cancel: assert property (
    ce_in && applied && f_xdis && !f_copy && !oneshot_fire |=>
      !decision_out.host_req && decision_out.host_qmask == 8'h00)
    else $error("extraction not cancelled");
  a_police_or_swap: assert property (
    ce_in && applied |=>
      decision_out.police_valid != decision_out.sip_valid &&
      (decision_out.police_valid ? decision_out.police_index :
      decision_out.sip_index) == $past(f_polidx))
    else $error("policer and swap select overlap");
  a_log_interval_neg: assert property (
    ce_in && applied && f_rew[5] && f_macx |=>
      decision_out.log_interval == (8'hF8 | {5'h00, $past(f_logint)}))
    else $error("negative log interval wrong");
  a_rew_bits_clear: assert property (
    ce_in && applied && f_rew[5] |=> decision_out.rewriter_command[5:4] == 2'b00)
    else $error("rewriter bits not cleared");
  a_host_port_kept: assert property (
    ce_in && s1_valid |=>
      decision_out.dest_mask[54] == $past(s1_ctx.dest_mask[54]))
    else $error("host port membership changed");
  a_sticky_modes: assert property (
    ce_in && applied && !s1_ctx.sticky && f_mode == 3'h3 |=>
      decision_out.sticky && decision_out.dest_mask[53:0] ==
      $past(f_vec[53:0]))
    else $error("replace all not sticky");
  a_mirror_probe: assert property (
    ce_in && applied && f_mirror == 2'h3 |=>
      decision_out.mirror_valid && decision_out.mirror_probe == 2'h2)
    else $error("mirror probe decode wrong");
  a_oneshot_once: assert property (
    seq_oneshot_hit ##1 seq_same_again |=> !decision_out.host_req ||
      $past(s1_ctx.host_req && !f_xdis))
    else $error("one-shot copied twice");
  a_terminated_skip: assert property (
    ce_in && s1_valid && s1_ctx.terminated && !f_ovr |=>
      !decision_out.applied && !rule_hit_irq_out)
    else $error("terminated frame took action");

endmodule : acad_decoder

//--- core/acad_pkg.sv
/*
  Shared constants and carriers of the classification action decoder.
  Assumes one core clock and a lookup that presents one action per cycle.
*/
package acad_pkg;

  // ****************************************************************
  // Action word layout
  // ****************************************************************
  localparam int ACTION_W = 196;
  localparam int POS_INNER = 0;
  localparam int POS_FORCE = 1;
  localparam int POS_STAGE = 2;
  localparam int POS_ONESHOT = 7;
  localparam int POS_IRQ = 8;
  localparam int POS_COPY = 9;
  localparam int POS_QUEUE = 10;
  localparam int POS_XDIS = 13;
  localparam int POS_LRN = 14;
  localparam int POS_RT = 15;
  localparam int POS_POLON = 16;
  localparam int POS_POLIDX = 17;
  localparam int POS_OVRTERM = 22;
  localparam int POS_LOGINT = 23;
  localparam int POS_MODE = 26;
  localparam int POS_PORTVEC = 29;
  localparam int POS_MIRROR = 84;
  localparam int POS_REWCMD = 86;
  localparam int POS_MACX = 141;

  localparam int STAGE_W = 5;
  localparam int QUEUE_W = 3;
  localparam int POLIDX_W = 5;
  localparam int LOGINT_W = 3;
  localparam int MODE_W = 3;
  localparam int PORT_W = 55;
  localparam int MIRROR_W = 2;
  localparam int REWCMD_W = 8;
  localparam int QMASK_W = 8;
  localparam int GROUP_W = 8;

  // Vector bit positions used under redirect, then rewriter command bits cleared when bit 5 is set
  localparam int POS_FILT_SRC = 52;
  localparam int POS_FILT_AGGR = 51;
  localparam int POS_FILT_VLAN = 50;
  localparam int POS_REW_PTPSEQ = 5;
  localparam int POS_REW_SEQLO = 4;

  // Destination mask bit that stands for the host port
  localparam int HOST_PORT_BIT = 54;

  localparam logic [STAGE_W-1:0] STAGE_NONE = 5'h00;
  localparam logic [STAGE_W-1:0] STAGE_DONE = 5'h10;
  localparam logic [7:0] LOG_NEG_BASE = 8'hF8;

  // ****************************************************************
  // Port set operations
  // ****************************************************************
  typedef enum logic [MODE_W-1:0] {
    OP_OR_INTO_DESTINATION = 3'h0,
    OP_AND_VLAN = 3'h1,
    OP_REPLACE_GROUP = 3'h2,
    OP_REPLACE_ALL = 3'h3,
    OP_REDIRECT_BY_GROUP = 3'h4,
    OP_OR_WITH_GROUP_MASK = 3'h5
  } acad_op_type;

  // ****************************************************************
  // One-shot memory and register map
  // ****************************************************************
  localparam int RULE_W = 8;
  localparam int RULE_DEPTH = 256;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] REG_REARM = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LAST = 8'h0C;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_COUNT_POS = 16;
  localparam logic CTRL_ENABLE_RESET = 1'b1;
  localparam logic [15:0] HIT_COUNT_RESET = 16'h0000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [PORT_W-1:0] dest_mask;
    logic [PORT_W-1:0] vlan_mask;
    logic [PORT_W-1:0] group_mask;
    logic sticky;
    logic host_req;
    logic [QMASK_W-1:0] host_qmask;
    logic [STAGE_W-1:0] stage_point;
    logic terminated;
  } acad_ctx_type;

  typedef struct packed {
    logic applied;
    logic [PORT_W-1:0] dest_mask;
    logic sticky;
    logic redir_valid;
    logic [GROUP_W-1:0] redir_index;
    logic filt_src;
    logic filt_aggr;
    logic filt_vlan;
    logic host_req;
    logic [QMASK_W-1:0] host_qmask;
    logic [STAGE_W-1:0] stage_point;
    logic stage_act_none;
    logic inner_point;
    logic learn_block;
    logic route_block;
    logic police_valid;
    logic [POLIDX_W-1:0] police_index;
    logic sip_valid;
    logic [POLIDX_W-1:0] sip_index;
    logic mirror_valid;
    logic [MIRROR_W-1:0] mirror_probe;
    logic [REWCMD_W-1:0] rewriter_command;
    logic log_valid;
    logic [7:0] log_interval;
  } acad_dec_type;

endpackage : acad_pkg

//--- core/acad_oneshot_mem.sv
/*
  One-bit-per-rule memory of consumed one-shot copies.
  Assumes one write and one read port; read data registered, old on clash.
*/
`timescale 1ns/1ps
module acad_oneshot_mem (
  // Clock
  input wire logic mclk_in,
  input wire logic ce_in,
  // Write port
  input wire logic wr_in,
  input wire logic [acad_pkg::RULE_W-1:0] wr_addr_in,
  input wire logic wr_data_in,
  // Read port
  input wire logic [acad_pkg::RULE_W-1:0] rd_addr_in,
  output logic rd_data_out
);

  logic mem [acad_pkg::RULE_DEPTH];

  always_ff @(posedge mclk_in)
  begin
    if (ce_in && wr_in)
    begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (ce_in)
    begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule : acad_oneshot_mem

//--- verif/acad_fwd_model.sv
/*
  Forwarding-side model: counts interrupt pulses that arrive with decisions.
  Assumes the decoder's registered outputs on the one core clock.
*/
`timescale 1ns/1ps
module acad_fwd_model (
  // Decoder side
  input wire logic mclk_in,
  input wire logic srst_in,
  input wire logic dec_valid_in,
  input wire logic irq_in,
  // Count
  output logic [15:0] irq_count_out
);
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      irq_count_out <= 16'h0000;
    else if (irq_in && dec_valid_in)
      irq_count_out <= irq_count_out + 16'h0001;
  end
endmodule : acad_fwd_model

//--- verif/acad_decoder_tb.sv
/*
  Self-checking bench of the action decoder, random actions and contexts.
  Assumes decisions two clock-enabled edges after each action.
*/
`timescale 1ns/1ps
module acad_decoder_tb;
  logic mclk_in = 1'b0, srst_in = 1'b1, av = 1'b0, wr = 1'b0, rd = 1'b0;
  logic ce = 1'b1, en = 1'b1, dv, irq;
  logic [195:0] act = '0;
  logic [7:0] rule = 8'h00, addr = 8'h00, last = 8'h00;
  logic [31:0] wd = 32'h0, rdata;
  logic [15:0] irqc, hits = 16'h0, nirq = 16'h0;
  logic [255:0] used = '0;
  logic [118:0] dq[$];
  acad_pkg::acad_ctx_type ctx = '0;
  acad_pkg::acad_dec_type dec;
  int n_mismatch = 0, check_count = 0;
  acad_decoder u_acad_decoder (.mclk_in(mclk_in), .srst_in(srst_in),
    .ce_in(ce), .action_valid_in(av), .action_in(act),
    .rule_index_in(rule), .ctx_in(ctx), .decision_valid_out(dv),
    .decision_out(dec), .rule_hit_irq_out(irq), .reg_addr_in(addr),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata));
  acad_fwd_model u_acad_fwd_model (.mclk_in(mclk_in), .srst_in(srst_in),
    .dec_valid_in(dv), .irq_in(irq), .irq_count_out(irqc));
  task automatic check(input string nm, input logic [118:0] s, e);
    check_count++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  function automatic logic [118:0] exp_of(logic [195:0] a,
    acad_pkg::acad_ctx_type c, logic cons);
    logic [54:0] v, d;
    logic [7:0] q, r;
    logic f, g, s, h;
    v = a[83:29];
    r = a[93:86];
    f = a[1];
    g = a[28:26] == 3'h4 && !c.sticky;
    s = c.sticky || g || a[28:26] == 3'h3;
    case (a[28:26])
      3'h0: d = c.dest_mask | v;
      3'h1: d = c.dest_mask & c.vlan_mask & v;
      3'h2, 3'h3: d = v;
      3'h5: d = c.group_mask | v;
      default: d = c.dest_mask;
    endcase
    if (c.sticky) d = c.dest_mask;
    d[54] = c.dest_mask[54];
    q = (a[13] ? 8'h00 : c.host_qmask) |
      ((a[9] || (a[7] && !cons)) ? 8'h01 << a[12:10] : 8'h00);
    h = (c.host_req && !a[13]) || a[9] || (a[7] && !cons);
    if ((c.terminated && !a[22]) || !en)
      return {1'b0, c.sticky, c.host_req, c.dest_mask, c.host_qmask,
        c.stage_point, 48'h0};
    return {1'b1, s, h, d, q, f ? a[6:2] : c.stage_point,
      f && a[6:2] == 5'h00, a[0], a[14], a[15], a[16],
      a[16] ? a[21:17] : 5'h00,
      !a[16], a[16] ? 5'h00 : a[21:17], a[85:84] != 2'h0,
      (a[85:84] - 2'h1) & {2{a[85:84] != 2'h0}},
      r[5] ? r & 8'hCF : r,
      r[5] ? {a[141] ? 5'h1F : 5'h00, a[25:23]} : 8'h00,
      g, g ? {v[7:0], v[52:50]} : 11'h000, a[8]};
  endfunction : exp_of
  task automatic frame(input logic [7:0] r);
    logic [223:0] t;
    acad_pkg::acad_ctx_type c;
    logic ap;
    t = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
      $urandom};
    c = t[180:0];
    t = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom,
      $urandom};
    t[6:2] = 5'($urandom_range(16));
    c.sticky = $urandom_range(7) == 0;
    c.terminated = $urandom_range(3) == 0;
    r = t[9] ? r | 8'h04 : r;
    ap = en && !(c.terminated && !t[22]);
    dq.push_back(exp_of(t[195:0], c, used[r]));
    if (ap && t[7] && !t[9]) used[r] = 1'b1;
    if (ap) {hits, last, nirq} = {hits + 16'h1, r, nirq + 16'(t[8])};
    @(posedge mclk_in);
    {av, act, rule, ctx} <= {1'b1, t[195:0], r, c};
  endtask : frame
  task automatic reg_op(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    @(posedge mclk_in);
    {wr, rd, addr, wd} <= {w, !w, ad, d};
    @(posedge mclk_in);
    {wr, rd} <= 2'b00;
    if (!w) @(posedge mclk_in) check("read", {87'h0, rdata}, {87'h0, d});
  endtask : reg_op
  task automatic burst(input int n);
    repeat (n)
    begin
      frame(8'($urandom_range(3)));
      if ($urandom_range(3) == 0) @(posedge mclk_in) av <= 1'b0;
    end
    @(posedge mclk_in) av <= 1'b0;
    repeat (4) @(posedge mclk_in);
    $display("test burst of %0d done", n);
  endtask : burst
  initial forever #5 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
    if (!srst_in && dv !== 1'b0) check("decision", {dec.applied, dec.sticky,
      dec.host_req, dec.dest_mask, dec.host_qmask, dec.stage_point,
      dec.stage_act_none, dec.inner_point, dec.learn_block, dec.route_block,
      dec.police_valid, dec.police_index, dec.sip_valid, dec.sip_index,
      dec.mirror_valid, dec.mirror_probe & {2{dec.mirror_valid}}, dec.rewriter_command,
      dec.log_interval & {8{dec.log_valid}}, dec.redir_valid,
      dec.redir_valid ? {dec.redir_index, dec.filt_src, dec.filt_aggr,
      dec.filt_vlan} : 11'h000, irq}, dq.pop_front());
  initial
  begin
    #200000 n_mismatch++;
    results();
  end
  initial
  begin
    void'($urandom(29));
    repeat (2) @(posedge mclk_in);
    srst_in <= 1'b0;
    reg_op(1'b0, acad_pkg::REG_STATUS, 32'h00000001);
    reg_op(1'b0, acad_pkg::REG_CTRL, 32'h00000001);
    reg_op(1'b0, 8'h10, 32'h00000000);
    repeat (260) @(posedge mclk_in);
    burst(300);
    reg_op(1'b0, acad_pkg::REG_STATUS, {hits, 16'h0000});
    reg_op(1'b0, acad_pkg::REG_LAST, {24'h000000, last});
    // Read data must stay while the clock enable is low
    @(posedge mclk_in) {rd, addr} <= {1'b1, acad_pkg::REG_CTRL};
    @(posedge mclk_in) {rd, ce} <= 2'b00;
    repeat (2) @(posedge mclk_in) check("frozen", {87'h0, rdata}, 119'h1);
    ce <= 1'b1;
    $display("test clock enable hold done");
    for (int i = 0; i < 4; i++) reg_op(1'b1, acad_pkg::REG_REARM, i);
    used[3:0] = 4'h0;
    repeat (4) @(posedge mclk_in);
    burst(40);
    reg_op(1'b1, acad_pkg::REG_CTRL, 32'h00000000);
    en = 1'b0;
    burst(10);
    check("irq count", {103'h0, irqc}, {103'h0, nirq});
    check("pending", 119'(dq.size()), 119'h0);
    results();
  end
endmodule : acad_decoder_tb
